/* File: hw/wcc_top.sv */
// Wetting current configuration: level fields of ground inputs 8 to 12,
// continuous-mode bits of all inputs and one wetting timer per input.
// Assumes a serial front end on clk that hands over decoded accesses,
// and comparator outputs arriving asynchronously from the analog side.
`timescale 1ns/1ns
`include "wcc_regs.svh"

module wcc_top #(
  parameter int WET_CYCLES = `WCC_WET_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire wcc_pkg::wcc_reg_req_type reg_req,
  output wcc_pkg::wcc_reg_rsp_type reg_rsp,
  input wire logic [`WCC_ALL_INPUTS-1:0] comparator_in,
  output logic [`WCC_ALL_INPUTS-1:0] wetting_full,
  output logic [`WCC_LEVEL_FIELDS*`WCC_LEVEL_W-1:0] ground_level_code,
  output logic [`WCC_LEVEL_FIELDS*5-1:0] ground_level_ma
);

  localparam int NIN = `WCC_ALL_INPUTS;
  localparam int NPROG = `WCC_PROG_INPUTS;
  localparam int NLVL = `WCC_LEVEL_FIELDS;
  localparam int LW = `WCC_LEVEL_W;
  localparam int TW = `WCC_TIMER_W;
  localparam logic [TW-1:0] WET_LOAD = TW'(WET_CYCLES);

  // Level code to current in mA
  function automatic logic [4:0] code_to_ma(input logic [LW-1:0] code);
    logic [4:0] ma;
    ma = `WCC_MA_CODE0;
    unique case (code)
      3'h0: ma = `WCC_MA_CODE0;
      3'h1: ma = `WCC_MA_CODE1;
      3'h2: ma = `WCC_MA_CODE2;
      3'h3: ma = `WCC_MA_CODE3;
      3'h4: ma = `WCC_MA_CODE4;
      3'h5: ma = `WCC_MA_CODE5;
      3'h6: ma = `WCC_MA_CODE6;
      3'h7: ma = `WCC_MA_CODE7;
    endcase
    return ma;
  endfunction

  // Register state
  logic [`WCC_LEVEL_BITS-1:0] level_upper_ff;
  logic [`WCC_LEVEL_BITS-1:0] nxt_level_upper;
  logic [NPROG-1:0] cont_prog_ff;
  logic [NPROG-1:0] nxt_cont_prog;
  logic [`WCC_GROUND_INPUTS-1:0] cont_ground_ff;
  logic [`WCC_GROUND_INPUTS-1:0] nxt_cont_ground;
  logic [`WCC_DATA_W-1:0] rdata_ff;
  logic [`WCC_DATA_W-1:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  // Comparator synchronisers and timer state
  logic [NIN-1:0] cmp_meta_ff;
  logic [NIN-1:0] cmp_sync_ff;
  logic [NIN-1:0] cmp_prev_ff;
  logic [NIN-1:0] crossing;
  logic [TW-1:0] timer_ff [NIN];
  logic [TW-1:0] nxt_timer [NIN];
  logic [NIN-1:0] sustain_ff;
  logic [NIN-1:0] nxt_sustain;
  logic [NIN-1:0] cont_all;
  logic [NIN-1:0] wetting_full_ff;
  logic [NIN-1:0] nxt_wetting_full;
  logic [NLVL*LW-1:0] level_code_ff;
  logic [NLVL*LW-1:0] nxt_level_code;
  logic [NLVL*5-1:0] level_ma_ff;
  logic [NLVL*5-1:0] nxt_level_ma;

  // Register writes and reads; no mode gating, writes land any cycle
  always_comb begin
    nxt_level_upper = level_upper_ff;
    nxt_cont_prog = cont_prog_ff;
    nxt_cont_ground = cont_ground_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `WCC_ADDR_LEVEL_UPPER: begin
          // Bits above 14 are unused and dropped
          nxt_level_upper = reg_req.wdata[`WCC_LEVEL_BITS-1:0];
        end
        `WCC_ADDR_CONT_PROG: begin
          nxt_cont_prog = reg_req.wdata[NPROG-1:0];
        end
        `WCC_ADDR_CONT_GROUND: begin
          nxt_cont_ground =
            reg_req.wdata[`WCC_GROUND_INPUTS-1:0];
        end
        default: begin
          // Writes elsewhere belong to other blocks
        end
      endcase
    end
    if (reg_req.rd) begin
      nxt_rvalid = 1'b1;
      unique case (reg_req.addr)
        `WCC_ADDR_LEVEL_UPPER: begin
          nxt_rdata = {9'h000, level_upper_ff};
        end
        `WCC_ADDR_CONT_PROG: begin
          nxt_rdata = {16'h0000, cont_prog_ff};
        end
        `WCC_ADDR_CONT_GROUND: begin
          nxt_rdata = {10'h000, cont_ground_ff};
        end
        default: begin
          nxt_rdata = 24'h000000;
        end
      endcase
    end
  end

  // Register file flops, power-on values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_upper_ff <= `WCC_LEVEL_UPPER_RST;
      cont_prog_ff <= `WCC_CONT_PROG_RST;
      cont_ground_ff <= `WCC_CONT_GROUND_RST;
      rdata_ff <= 24'h000000;
      rvalid_ff <= 1'b0;
    end else begin
      level_upper_ff <= nxt_level_upper;
      cont_prog_ff <= nxt_cont_prog;
      cont_ground_ff <= nxt_cont_ground;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // One driver for the whole answer word, never two on its fields
  assign reg_rsp = {rvalid_ff, rdata_ff};

  // Comparators are asynchronous; two flops before any use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_meta_ff <= 22'h000000;
      cmp_sync_ff <= 22'h000000;
      cmp_prev_ff <= 22'h000000;
    end else begin
      cmp_meta_ff <= comparator_in;
      cmp_sync_ff <= cmp_meta_ff;
      cmp_prev_ff <= cmp_sync_ff;
    end
  end

  // A crossing in either direction restarts that input's timer
  assign crossing = cmp_sync_ff ^ cmp_prev_ff;
  // Programmable inputs occupy the low indices, ground inputs above
  assign cont_all = {cont_ground_ff, cont_prog_ff};

  // Per-input timers and pulsed/sustain state
  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      nxt_timer[i] = timer_ff[i];
      nxt_sustain[i] = sustain_ff[i];
      if (crossing[i]) begin
        // Restart gives exactly WET_CYCLES of full wetting
        nxt_timer[i] = WET_LOAD;
        nxt_sustain[i] = 1'b0;
      end else if (timer_ff[i] != 18'h00000) begin
        nxt_timer[i] = timer_ff[i] - 18'h00001;
        // Expiry only lowers current in pulsed mode
        if (timer_ff[i] == 18'h00001 && !cont_all[i]) begin
          nxt_sustain[i] = 1'b1;
        end
      end
      // Continuous bit overrides any sustain state
      nxt_wetting_full[i] = cont_all[i] | ~nxt_sustain[i];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NIN; i++) begin
        timer_ff[i] <= 18'h00000;
      end
      sustain_ff <= 22'h000000;
      wetting_full_ff <= 22'h3FFFFF;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        timer_ff[i] <= nxt_timer[i];
      end
      sustain_ff <= nxt_sustain;
      wetting_full_ff <= nxt_wetting_full;
    end
  end

  assign wetting_full = wetting_full_ff;

  // Applied level of ground inputs 8..12: field or the sustain code
  always_comb begin
    for (int k = 0; k < NLVL; k++) begin
      if (nxt_wetting_full[`WCC_LEVEL_FIRST_GROUND + NPROG + k]) begin
        nxt_level_code[k*LW +: LW] = nxt_level_upper[k*LW +: LW];
      end else begin
        nxt_level_code[k*LW +: LW] = `WCC_SUSTAIN_CODE;
      end
      nxt_level_ma[k*5 +: 5] =
        code_to_ma(nxt_level_code[k*LW +: LW]);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_code_ff <= `WCC_LEVEL_UPPER_RST;
      level_ma_ff <= {NLVL{`WCC_MA_CODE6}};
    end else begin
      level_code_ff <= nxt_level_code;
      level_ma_ff <= nxt_level_ma;
    end
  end

  assign ground_level_code = level_code_ff;
  assign ground_level_ma = level_ma_ff;

endmodule

/* File: hw/wcc_regs.svh */
// Register offsets, field layouts, reset values and timing figures of
// the wetting current configuration block.
// Assumes inclusion by bare name from any file that needs the constants.
`ifndef WCC_REGS_SVH
`define WCC_REGS_SVH

// Register addresses on the 7-bit register address field
`define WCC_ADDR_LEVEL_UPPER 7'h06
`define WCC_ADDR_CONT_PROG 7'h0B
`define WCC_ADDR_CONT_GROUND 7'h0C

// Register data width and field sizes
`define WCC_DATA_W 24
`define WCC_LEVEL_W 3
`define WCC_LEVEL_FIELDS 5
`define WCC_LEVEL_BITS 15
`define WCC_PROG_INPUTS 8
`define WCC_GROUND_INPUTS 14
`define WCC_ALL_INPUTS 22
`define WCC_LEVEL_FIRST_GROUND 8

// Reset values: every level field 110, every continuous bit 0
`define WCC_LEVEL_UPPER_RST 15'h6DB6
`define WCC_CONT_PROG_RST 8'h00
`define WCC_CONT_GROUND_RST 14'h0000

// Level code applied to a ground input once its timer has run out
`define WCC_SUSTAIN_CODE 3'h0

// Current in mA for each level code
`define WCC_MA_CODE0 5'h02
`define WCC_MA_CODE1 5'h06
`define WCC_MA_CODE2 5'h08
`define WCC_MA_CODE3 5'h0A
`define WCC_MA_CODE4 5'h0C
`define WCC_MA_CODE5 5'h0E
`define WCC_MA_CODE6 5'h10
`define WCC_MA_CODE7 5'h14

// Wetting timer: time in ms, clock rate in Hz, derived cycle count
`define WCC_WET_TIME_MS 20
`define WCC_CLK_HZ 10000000
`define WCC_WET_CYCLES (`WCC_WET_TIME_MS * (`WCC_CLK_HZ / 1000))
`define WCC_TIMER_W 18

`endif

/* File: hw/wcc_pkg.sv */
// Types shared by the wetting current configuration block.
// Assumes wcc_regs.svh supplies the widths.
`include "wcc_regs.svh"

package wcc_pkg;

  // One register access as delivered by the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [`WCC_DATA_W-1:0] wdata;
  } wcc_reg_req_type;

  // Register read answer
  typedef struct packed {
    logic valid;
    logic [`WCC_DATA_W-1:0] rdata;
  } wcc_reg_rsp_type;

endpackage

/* File: tb/wcc_props.sv */
// Checker of the wetting block ports: read answers, decode, timing.
// Assumes wcc_top is bound below with its timer length handed on.
`timescale 1ns/1ns
module wcc_props #(
  parameter int WET_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire wcc_pkg::wcc_reg_req_type reg_req,
  input wire wcc_pkg::wcc_reg_rsp_type reg_rsp,
  input wire logic [21:0] comparator_in,
  input wire logic [21:0] wetting_full,
  input wire logic [14:0] ground_level_code,
  input wire logic [24:0] ground_level_ma
);
  localparam logic [4:0] MA [8] = '{5'h02, 5'h06, 5'h08, 5'h0A, 5'h0C,
    5'h0E, 5'h10, 5'h14};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Register answers, one cycle after the strobe
  property p_rv; reg_req.rd |=> reg_rsp.valid; endproperty
  a_rv: assert property (p_rv) else $error("no read answer");
  property p_nrv; !reg_req.rd |=> !reg_rsp.valid; endproperty
  a_nrv: assert property (p_nrv) else $error("stray answer");
  property p_up;
    reg_req.rd && reg_req.addr == 7'h06 |=> reg_rsp.rdata[23:15] == 9'h000;
  endproperty
  a_up: assert property (p_up) else $error("level upper bits");
  property p_sp;
    reg_req.rd && reg_req.addr == 7'h0B |=> reg_rsp.rdata[23:8] == 16'h0000;
  endproperty
  a_sp: assert property (p_sp) else $error("prog upper bits");
  property p_sg;
    reg_req.rd && reg_req.addr == 7'h0C |=> reg_rsp.rdata[23:14] == 10'h000;
  endproperty
  a_sg: assert property (p_sg) else $error("ground upper bits");
  // Current must follow the applied code on both end fields
  property p_dec;
    ground_level_ma[4:0] == MA[ground_level_code[2:0]] &&
    ground_level_ma[24:20] == MA[ground_level_code[14:12]];
  endproperty
  a_dec: assert property (p_dec) else $error("bad decode");
  property p_sus;
    !wetting_full[16] |-> ground_level_code[2:0] == 3'h0 &&
    ground_level_ma[4:0] == 5'h02;
  endproperty
  a_sus: assert property (p_sus) else $error("bad sustain");
  property p_rise;
    $changed(comparator_in[16]) && !wetting_full[16] |->
    ##[1:5] wetting_full[16];
  endproperty
  a_rise: assert property (p_rise) else $error("no wetting");
  // Drop to sustain only if current was high WET_CYCLES - 1 cycles before the drop
  property p_hold;
    $fell(wetting_full[16]) |-> $past(wetting_full[16], WET_CYCLES - 1);
  endproperty
  a_hold: assert property (p_hold) else $error("early sustain");
  c_rd: cover property (reg_req.rd && reg_req.addr == 7'h0C);
  c_fall: cover property ($fell(wetting_full[16]));
  c_rise: cover property ($rose(wetting_full[16]));
endmodule

bind wcc_top wcc_props #(.WET_CYCLES(WET_CYCLES)) u_props (
  .clk(clk),
  .reset(reset),
  .reg_req(reg_req),
  .reg_rsp(reg_rsp),
  .comparator_in(comparator_in),
  .wetting_full(wetting_full),
  .ground_level_code(ground_level_code),
  .ground_level_ma(ground_level_ma)
);

/* File: tb/wcc_host.sv */
// Host model: one register access at a time on the request port.
// Assumes the bench calls its tasks after reset is released.
`timescale 1ns/1ns
module wcc_host (
  input wire logic clk,
  output wcc_pkg::wcc_reg_req_type reg_req,
  input wire wcc_pkg::wcc_reg_rsp_type reg_rsp
);
  initial reg_req = '0;
  // Writes at any time, no precondition on the device mode
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(posedge clk) reg_req <= {1'b1, 1'b0, a, d};
    @(posedge clk) reg_req <= '0;
  endtask
  // Answer sampled in the cycle after the taking edge; X if absent
  task automatic rd(input logic [6:0] a, output logic [23:0] d);
    @(posedge clk) reg_req <= {1'b0, 1'b1, a, 24'h000000};
    @(posedge clk) reg_req <= '0;
    #1 d = reg_rsp.valid ? reg_rsp.rdata : 24'hXXXXXX;
  endtask
endmodule

/* File: tb/test_wcc_top.sv */
// Bench for the wetting block: registers, decode and per-input timers.
// Assumes wcc_host drives the register port; timer shortened to W.
`timescale 1ns/1ns
module test_wcc_top;
  localparam int W = 20;
  logic clk;
  logic reset;
  logic [21:0] comparator_in;
  wcc_pkg::wcc_reg_req_type reg_req;
  wcc_pkg::wcc_reg_rsp_type reg_rsp;
  logic [21:0] wetting_full;
  logic [14:0] ground_level_code;
  logic [24:0] ground_level_ma;
  logic [23:0] d;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [4:0] ma [8] = '{5'h02, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10,
    5'h14};
  logic [6:0] ad [4] = '{7'h06, 7'h0B, 7'h0C, 7'h07};
  logic [23:0] rv [4] = '{24'h006DB6, 24'h000000, 24'h000000, 24'h000000};
  logic [23:0] fv [4] = '{24'h007FFF, 24'h0000FF, 24'h003FFF, 24'h000000};
  wcc_top #(.WET_CYCLES(W)) dut (
    .clk(clk),
    .reset(reset),
    .reg_req(reg_req),
    .reg_rsp(reg_rsp),
    .comparator_in(comparator_in),
    .wetting_full(wetting_full),
    .ground_level_code(ground_level_code),
    .ground_level_ma(ground_level_ma)
  );
  wcc_host host (.clk(clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Crossing on one input: full 4 edges on, still full in the last
  // timer cycle, then e one edge later; tight ends catch off-by-one
  task automatic pulse(input int i, input logic e);
    @(posedge clk) comparator_in[i] <= ~comparator_in[i];
    repeat (4) @(posedge clk);
    #1 chk(wetting_full[i], 1'b1);
    repeat (W - 2) @(posedge clk);
    #1 chk(wetting_full[i], 1'b1);
    @(posedge clk);
    #1 chk(wetting_full[i], e);
  endtask
  // Hang guard, far above the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end
  initial begin
    reset = 1'b1;
    comparator_in = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1 chk(ground_level_ma, {5{5'h10}});
    chk(wetting_full, 22'h3FFFFF);
    // Reset values, write of all ones, unused bits dropped, restore
    for (int i = 0; i < 4; i++) begin
      host.rd(ad[i], d);
      chk(d, rv[i]);
      host.wr(ad[i], 24'hFFFFFF);
      host.rd(ad[i], d);
      chk(d, fv[i]);
      host.wr(ad[i], rv[i]);
    end
    // Every level code on all five fields while at full wetting
    for (int c = 0; c < 8; c++) begin
      host.wr(7'h06, {9'h000, {5{3'(c)}}});
      repeat (2) @(posedge clk);
      #1 chk(ground_level_code, {5{3'(c)}});
      chk(ground_level_ma, {5{ma[c]}});
    end
    pulse(16, 1'b0);
    // Only ground 8 drops; the other fields keep code 7
    chk(ground_level_code, {{4{3'h7}}, 3'h0});
    chk(ground_level_ma, {{4{ma[7]}}, ma[0]});
    pulse(16, 1'b0);
    // A second crossing mid-run must reload the full timer length
    @(posedge clk) comparator_in[16] <= ~comparator_in[16];
    repeat (10) @(posedge clk);
    pulse(16, 1'b0);
    host.wr(7'h0C, 24'h000100);
    repeat (2) @(posedge clk);
    #1 chk(wetting_full[16], 1'b1);
    pulse(16, 1'b1);
    host.wr(7'h0C, 24'h000000);
    pulse(16, 1'b0);
    // One continuous input only, to keep dissipation low
    host.wr(7'h0B, 24'h000080);
    pulse(7, 1'b1);
    pulse(0, 1'b0);
    pulse(21, 1'b0);
    pulse(20, 1'b0);
    // Ground 8 and 12 in sustain, fields between still at code 7
    chk(ground_level_code, {3'h0, {3{3'h7}}, 3'h0});
    chk(ground_level_ma, {ma[0], {3{ma[7]}}, ma[0]});
    results();
  end
endmodule
